// >>> ebc_pkg.sv
// Shared constants and types for the external bus control block
package ebc_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int EBC_DATA_W = 16;
  localparam int EBC_ADDR_W = 16;
  localparam int EBC_SYNC_W = 4;

  // ----------------------------------------------------------------
  // Synchroniser lane positions and idle levels
  // ----------------------------------------------------------------
  localparam int EBC_LANE_READY = 0;
  localparam int EBC_LANE_OFF = 1;
  localparam int EBC_LANE_HOLD = 2;
  localparam int EBC_LANE_BTEST = 3;
  // All four pins idle high, so off, hold and test leave reset inactive and ready leaves it asserted
  localparam logic [EBC_SYNC_W-1:0] EBC_SYNC_RST = 4'hf;

  // ----------------------------------------------------------------
  // Ready ageing: edges in a cycle before the filtered ready is fresh
  // ----------------------------------------------------------------
  localparam int EBC_LAT_W = 3;
  localparam logic [EBC_LAT_W-1:0] EBC_READY_LAT = 3'h4;
  localparam logic [EBC_LAT_W-1:0] EBC_LAT_ONE = 3'h1;
  localparam logic [EBC_LAT_W-1:0] EBC_LAT_ZERO = 3'h0;

  // ----------------------------------------------------------------
  // Address spaces and bus cycle states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {EBC_SP_PROG, EBC_SP_DATA, EBC_SP_IO} ebc_space_t;
  typedef enum {EBC_IDLE, EBC_ACCESS, EBC_LAST, EBC_HOLD} ebc_state_t;

  localparam logic [EBC_DATA_W-1:0] EBC_DATA_RST = 16'h0000;
  localparam logic [EBC_ADDR_W-1:0] EBC_ADDR_RST = 16'h0000;
endpackage

// >>> ebc_sync_if.sv
// Carrier between the pin synchroniser and the bus controller
`timescale 1ns/100ps
interface ebc_sync_if;
  import ebc_pkg::*;
  logic [EBC_SYNC_W-1:0] raw;
  logic [EBC_SYNC_W-1:0] clean;
  modport ctrl (output raw, input clean);
  modport sync (input raw, output clean);
endinterface

// >>> ebc_sync.sv
// Three-stage pin synchroniser with agreement filter, one lane per bit
`timescale 1ns/100ps
module ebc_sync
  import ebc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  ebc_sync_if.sync sif
);
  // ----------------------------------------------------------------
  // Per-lane stages
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < EBC_SYNC_W; g++)
    begin : g_lane
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic out_r;
      // Stage one feeds stage two only; out moves once two and three agree
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          s1_r <= EBC_SYNC_RST[g];
          s2_r <= EBC_SYNC_RST[g];
          s3_r <= EBC_SYNC_RST[g];
          out_r <= EBC_SYNC_RST[g];
        end
        else
        begin
          s1_r <= sif.raw[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r)
            out_r <= s3_r;
        end
      end
      assign sif.clean[g] = out_r;
    end
  endgenerate
endmodule

// >>> ebc_top.sv
// External bus control signals: strobes, selects, hold, flag and branch test
//
// Summary of operation
// - Write strobe falls as data bus driven.
// - Write strobe pulses for every space.
// - Output-disable low floats the control outputs.
// - Bus-cycle strobe low only during cycles.
// - Global request asserted on global data access.
// - Hold floats bus, asserts hold acknowledge.
// - Software flag output held until rewritten.
// - Branch taken only when test input low.
// - Ready low extends cycle one wait each.
// - Only addressed space select goes low.
// - Direction high except during external writes.
`timescale 1ns/100ps
module ebc_top
  import ebc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire ebc_space_t req_space,
  input wire logic req_global,
  input wire logic [EBC_ADDR_W-1:0] req_addr,
  input wire logic [EBC_DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [EBC_DATA_W-1:0] rsp_rdata,
  input wire logic sw_flag_wr,
  input wire logic sw_flag_val,
  input wire logic branch_on_test_low_instr,
  output logic branch_taken,
  input wire logic ready_in,
  input wire logic output_disable_n,
  input wire logic hold_req_n,
  input wire logic branch_test_in_n,
  output logic [EBC_ADDR_W-1:0] addr_out,
  output logic addr_oe,
  output logic [EBC_DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [EBC_DATA_W-1:0] data_in,
  output logic write_strobe_n,
  output logic bus_cycle_strobe_n,
  output logic program_space_sel_n,
  output logic data_space_sel_n,
  output logic io_space_sel_n,
  output logic read_write,
  output logic mem_ctl_oe,
  output logic global_request_n,
  output logic hold_ack_n,
  output logic multi_oe,
  output logic software_flag_out,
  output logic software_flag_oe
);
  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  ebc_sync_if sif ();
  assign sif.raw[EBC_LANE_READY] = ready_in;
  assign sif.raw[EBC_LANE_OFF] = output_disable_n;
  assign sif.raw[EBC_LANE_HOLD] = hold_req_n;
  assign sif.raw[EBC_LANE_BTEST] = branch_test_in_n;

  ebc_sync u_sync (
    .core_clk (core_clk),
    .rst (rst),
    .sif (sif)
  );

  logic ready_s;
  logic off_s_n;
  logic hold_s_n;
  logic btest_s_n;
  assign ready_s = sif.clean[EBC_LANE_READY];
  assign off_s_n = sif.clean[EBC_LANE_OFF];
  assign hold_s_n = sif.clean[EBC_LANE_HOLD];
  assign btest_s_n = sif.clean[EBC_LANE_BTEST];

  // ----------------------------------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------------------------------
  ebc_state_t state_r;
  ebc_state_t state_nxt;
  logic wr_r;
  ebc_space_t space_r;
  logic global_r;
  logic [EBC_ADDR_W-1:0] addr_r;
  logic [EBC_DATA_W-1:0] wdata_r;
  logic take;
  logic in_cycle;
  logic [EBC_LAT_W-1:0] acc_cnt_r;
  logic [EBC_LAT_W-1:0] acc_cnt_nxt;
  logic ready_seen;

  // Hold is granted only between cycles, so a cycle never tears
  assign req_ready = (state_r == EBC_IDLE) && hold_s_n;
  assign take = req_valid && req_ready;
  assign in_cycle = (state_r == EBC_ACCESS) || (state_r == EBC_LAST);

  // ready honoured once filter saw cycle
  // Ready rides the pin filter, so a level left over from the last
  // cycle must age out before it may end this one
  assign ready_seen = (acc_cnt_r == EBC_READY_LAT);
  assign acc_cnt_nxt = (state_r != EBC_ACCESS) ? EBC_LAT_ZERO :
    (ready_seen ? acc_cnt_r : acc_cnt_r + EBC_LAT_ONE);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      EBC_IDLE:
      begin
        if (!hold_s_n)
          state_nxt = EBC_HOLD;
        else if (req_valid)
          state_nxt = EBC_ACCESS;
      end
      EBC_ACCESS:
        if (ready_s && ready_seen)
          state_nxt = EBC_LAST;
      EBC_LAST:
        state_nxt = EBC_IDLE;
      EBC_HOLD:
        if (hold_s_n)
          state_nxt = EBC_IDLE;
      default:
        state_nxt = EBC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_r <= EBC_IDLE;
      acc_cnt_r <= EBC_LAT_ZERO;
    end
    else
    begin
      state_r <= state_nxt;
      acc_cnt_r <= acc_cnt_nxt;
    end
  end

  // Request fields held for the whole cycle
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_r <= 1'b0;
      space_r <= EBC_SP_PROG;
      global_r <= 1'b0;
      addr_r <= EBC_ADDR_RST;
      wdata_r <= EBC_DATA_RST;
    end
    else if (take)
    begin
      wr_r <= req_write;
      space_r <= req_space;
      global_r <= req_global && (req_space == EBC_SP_DATA);
      addr_r <= req_addr;
      wdata_r <= req_wdata;
    end
  end

  // Read data sampled at the close of the final state
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= EBC_DATA_RST;
    end
    else
    begin
      rsp_valid <= (state_r == EBC_LAST);
      if ((state_r == EBC_LAST) && !wr_r)
        rsp_rdata <= data_in;
    end
  end

  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  // strobe low for each cycle
  assign bus_cycle_strobe_n = !in_cycle;
  assign write_strobe_n = !(wr_r && (state_r == EBC_ACCESS));
  assign data_out = wdata_r;
  assign read_write = !(wr_r && in_cycle);
  assign program_space_sel_n = !(in_cycle && (space_r == EBC_SP_PROG));
  assign data_space_sel_n = !(in_cycle && (space_r == EBC_SP_DATA));
  assign io_space_sel_n = !(in_cycle && (space_r == EBC_SP_IO));
  assign global_request_n = !(in_cycle && global_r);
  assign addr_out = addr_r;

  assign hold_ack_n = (state_r != EBC_HOLD);
  assign mem_ctl_oe = off_s_n && (state_r != EBC_HOLD);
  assign addr_oe = mem_ctl_oe;
  assign data_oe = mem_ctl_oe && wr_r && in_cycle;
  assign multi_oe = off_s_n;
  assign software_flag_oe = off_s_n;

  // ----------------------------------------------------------------
  // Software flag and branch test
  // ----------------------------------------------------------------
  // latch flag until rewritten
  always_ff @(posedge core_clk)
  begin
    if (rst)
      software_flag_out <= 1'b0;
    else if (sw_flag_wr)
      software_flag_out <= sw_flag_val;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      branch_taken <= 1'b0;
    else
      branch_taken <= branch_on_test_low_instr && !btest_s_n;
  end
endmodule

// >>> ebc_chk.sv
// Checker and bind for the external bus control block
`timescale 1ns/100ps
module ebc_chk
  import ebc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire ebc_space_t req_space,
  input wire logic req_global,
  input wire logic sw_flag_wr,
  input wire logic sw_flag_val,
  input wire logic output_disable_n,
  input wire logic rsp_valid,
  input wire logic data_oe,
  input wire logic write_strobe_n,
  input wire logic bus_cycle_strobe_n,
  input wire logic program_space_sel_n,
  input wire logic data_space_sel_n,
  input wire logic io_space_sel_n,
  input wire logic read_write,
  input wire logic mem_ctl_oe,
  input wire logic global_request_n,
  input wire logic hold_ack_n,
  input wire logic multi_oe,
  input wire logic software_flag_out
);
  // ----------------------------------------------------------------
  // Bus cycle properties
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Request accepted on this edge
  wire take = req_valid && req_ready;
  a_write_drive: assert property (!write_strobe_n && mem_ctl_oe |-> data_oe && !read_write)
    else $error("write strobe low without data driven");
  a_write_pulse: assert property (take && req_write |=> !write_strobe_n)
    else $error("write cycle without write strobe");
  a_strobe_rise: assert property (rsp_valid |-> $past(write_strobe_n))
    else $error("write strobe still low at cycle end");
  a_cycle_strobe: assert property (take |=> !bus_cycle_strobe_n)
    else $error("bus cycle strobe not low after take");
  a_strobe_end: assert property (rsp_valid |-> bus_cycle_strobe_n && !$past(bus_cycle_strobe_n))
    else $error("bus cycle strobe not released at end");
  a_one_select: assert property ($countones({program_space_sel_n, data_space_sel_n,
    io_space_sel_n}) == (bus_cycle_strobe_n ? 3 : 2))
    else $error("space selects wrong");
  a_global_req: assert property (take && req_global && req_space == EBC_SP_DATA
    |=> !global_request_n)
    else $error("global request missing");
  a_rw_write: assert property (!read_write |-> !bus_cycle_strobe_n)
    else $error("direction low outside a cycle");
  a_hold_float: assert property (!hold_ack_n |-> !mem_ctl_oe && !data_oe)
    else $error("bus driven during hold");
  a_off_float: assert property ((!output_disable_n) [*6] |-> !mem_ctl_oe && !multi_oe)
    else $error("outputs driven while disabled");
  a_flag_load: assert property (sw_flag_wr |=> software_flag_out == $past(sw_flag_val))
    else $error("flag not loaded");
  a_flag_hold: assert property (!sw_flag_wr |=> $stable(software_flag_out))
    else $error("flag changed unasked");
  // Main scenarios reached
  c_write: cover property (take && req_write);
  c_read: cover property (take && !req_write);
  c_hold: cover property (!hold_ack_n);
endmodule
bind ebc_top ebc_chk i_ebc_chk (.core_clk, .rst, .req_valid, .req_ready, .req_write,
  .req_space, .req_global, .sw_flag_wr, .sw_flag_val, .output_disable_n, .rsp_valid,
  .data_oe, .write_strobe_n, .bus_cycle_strobe_n, .program_space_sel_n, .data_space_sel_n,
  .io_space_sel_n, .read_write, .mem_ctl_oe, .global_request_n, .hold_ack_n, .multi_oe,
  .software_flag_out);

// >>> ebc_mem_model.sv
// Behavioural external memory on the far side of the bus
`timescale 1ns/100ps
module ebc_mem_model
  import ebc_pkg::*;
(
  input wire logic core_clk,
  input wire logic [3:0] waits,
  input wire logic [EBC_ADDR_W-1:0] addr,
  input wire logic [EBC_DATA_W-1:0] wdata,
  input wire logic bus_cycle_strobe_n_n,
  input wire logic we_n,
  input wire logic rw,
  output logic [EBC_DATA_W-1:0] rdata,
  output logic ready
);
  logic [EBC_DATA_W-1:0] mem [16];
  logic [EBC_DATA_W-1:0] last = 16'h0000;
  int cnt = 0;
  // Wait counter restarts between cycles
  always @(posedge core_clk) cnt <= bus_cycle_strobe_n_n ? 0 : cnt + 1;
  assign ready = (waits == 4'h0) || (!bus_cycle_strobe_n_n && cnt >= waits);
  always @(posedge we_n) if (!bus_cycle_strobe_n_n) mem[addr[3:0]] = wdata;
  // Outside a read the bus moves, so stale data never looks valid
  assign rdata = (!bus_cycle_strobe_n_n && rw) ? mem[addr[3:0]] : ~last;
  always @(posedge core_clk) last <= rdata;
endmodule

// >>> tb_ebc_top.sv
// Self-checking testbench for the external bus control block
`timescale 1ns/100ps
module tb_ebc_top;
  import ebc_pkg::*;
  `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
  logic core_clk = 0, rst = 1, req_valid = 0, req_write = 0, req_global = 0, sw_flag_wr = 0;
  logic sw_flag_val = 0, branch_on_test_low_instr = 0, output_disable_n = 1, hold_req_n = 1;
  logic branch_test_in_n = 1, req_ready, rsp_valid, branch_taken, ready_in, addr_oe, data_oe;
  logic write_strobe_n, bus_cycle_strobe_n, program_space_sel_n, data_space_sel_n, saw_we;
  logic io_space_sel_n, read_write, mem_ctl_oe, global_request_n, hold_ack_n, multi_oe, saw_gl;
  logic software_flag_out, software_flag_oe, saw_rw;
  ebc_space_t req_space = EBC_SP_PROG;
  logic [EBC_ADDR_W-1:0] req_addr = 16'h0000, addr_out;
  logic [EBC_DATA_W-1:0] req_wdata = 16'h0000, rsp_rdata, data_out, data_in;
  logic [3:0] waits = 4'h0;
  int miscompares = 0, num_checks = 0, cyc = 0, n;
  ebc_top i_ebc_top (.core_clk, .rst, .req_valid, .req_ready, .req_write, .req_space,
    .req_global, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata, .sw_flag_wr, .sw_flag_val,
    .branch_on_test_low_instr, .branch_taken, .ready_in, .output_disable_n, .hold_req_n,
    .branch_test_in_n, .addr_out, .addr_oe, .data_out, .data_oe, .data_in, .write_strobe_n,
    .bus_cycle_strobe_n, .program_space_sel_n, .data_space_sel_n, .io_space_sel_n,
    .read_write, .mem_ctl_oe, .global_request_n, .hold_ack_n, .multi_oe, .software_flag_out,
    .software_flag_oe);
  ebc_mem_model i_ebc_mem_model (.core_clk, .waits, .addr(addr_out), .wdata(data_out),
    .bus_cycle_strobe_n_n(bus_cycle_strobe_n), .we_n(write_strobe_n), .rw(read_write), .rdata(data_in),
    .ready(ready_in));
  // ----------------------------------------------------------------
  // Clock, hang guard and closing report
  // ----------------------------------------------------------------
  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One bus cycle; request held until taken, n counts edges to the answer
  task automatic bus(input logic w, input ebc_space_t sp, input logic gl,
    input logic [15:0] a, input logic [15:0] d);
    @(negedge core_clk);
    req_valid = 1;
    req_write = w;
    req_space = sp;
    req_global = gl;
    req_addr = a;
    req_wdata = d;
    while (!req_ready) @(negedge core_clk);
    @(negedge core_clk);
    req_valid = 0;
    n = 1;
    saw_we = 0;
    saw_gl = 0;
    saw_rw = 0;
    while (!rsp_valid && n < 40)
    begin
      saw_we |= !write_strobe_n;
      saw_rw |= !read_write;
      saw_gl |= !global_request_n;
      @(negedge core_clk);
      n++;
    end
  endtask
  // Write then read back in every space, prompt and slow
  task automatic t_spaces;
    for (int s = 0; s < 6; s++)
    begin
      waits = (s > 2) ? 4'h3 : 4'h0;
      bus(1, ebc_space_t'(s % 3), 0, 16'h0004 + 16'(s), 16'ha5c0 + 16'(s));
      `CHK({saw_we, saw_rw}, 2'b11)
      `CHK(n, (s > 2) ? 10 : 7)
      bus(0, ebc_space_t'(s % 3), 0, 16'h0004 + 16'(s), 16'h0000);
      `CHK(rsp_rdata, 16'ha5c0 + 16'(s))
      `CHK({saw_we, saw_rw}, 2'b00)
    end
    bus(1, EBC_SP_DATA, 1, 16'h0001, 16'h0001);
    `CHK(saw_gl, 1'b1)
    bus(1, EBC_SP_DATA, 0, 16'h0001, 16'h0001);
    `CHK(saw_gl, 1'b0)
    $display("spaces test done");
  endtask
  // Flag, branch test, hold and output disable
  task automatic t_pins;
    for (int v = 0; v < 2; v++)
    begin
      sw_flag_val = v[0];
      sw_flag_wr = 1;
      branch_test_in_n = v[0];
      hold_req_n = v[0];
      output_disable_n = v[0];
      @(negedge core_clk);
      sw_flag_wr = 0;
      repeat (6) @(negedge core_clk);
      `CHK(software_flag_out, v[0])
      `CHK({hold_ack_n, req_ready, multi_oe, mem_ctl_oe, addr_oe, software_flag_oe}, {6{v[0]}})
      branch_on_test_low_instr = 1;
      @(negedge core_clk);
      branch_on_test_low_instr = 0;
      `CHK(branch_taken, !v[0])
      @(negedge core_clk);
      `CHK(branch_taken, 1'b0)
    end
    sw_flag_val = 0;
    repeat (2) @(negedge core_clk);
    `CHK(software_flag_out, 1'b1)
    $display("pins test done");
  endtask
  initial
  begin
    repeat (16) @(negedge core_clk);
    rst = 0;
    t_spaces();
    t_pins();
    wrap_up();
  end
endmodule
